/* File: rtl/arw_pkg.sv */
// package: register map, field layout and modes of the result/window block
package arw_pkg;
  // ******************************
  // register indices (byte address is four times the index)
  // ******************************
  localparam logic [5:0] IDX_SAMPLE_COUNT = 6'h02;
  localparam logic [5:0] IDX_WINDOW_MODE = 6'h04;
  localparam logic [5:0] IDX_START_CONV = 6'h08;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0A;
  localparam logic [5:0] IDX_IRQ_FLAGS = 6'h0B;
  localparam logic [5:0] IDX_HALT_BEHAVIOUR = 6'h0C;
  localparam logic [5:0] IDX_BYTE_STAGING = 6'h0D;
  localparam logic [5:0] IDX_CONVERTED_VALUE = 6'h10;
  localparam logic [5:0] IDX_WINDOW_LOW_LIMIT = 6'h12;
  localparam logic [5:0] IDX_WINDOW_HIGH_LIMIT = 6'h14;
  localparam logic [5:0] IDX_HIGH_BYTE = 6'h01;
  localparam int ADR_LSB = 2;
  // ******************************
  // field positions and reset values
  // ******************************
  localparam int BIT_SAMPLE_DONE = 0;
  localparam int BIT_WINDOW_MATCH = 1;
  localparam int BIT_RUN_WHEN_HALTED = 0;
  localparam int BIT_START = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ******************************
  // converter figures
  // ******************************
  localparam logic [9:0] CODE_MAX = 10'h3FF;
  localparam logic [9:0] CODE_MIN = 10'h000;
  localparam logic [15:0] ACC_CEILING = 16'hFFC0;
  localparam logic [2:0] COUNT_MAX_LOG2 = 3'h6;
  localparam logic [6:0] COUNT_ONE = 7'h01;
  localparam logic [6:0] COUNT_ZERO = 7'h00;
  // ******************************
  // window compare modes
  // ******************************
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_BELOW = 3'h1;
  localparam logic [2:0] MODE_ABOVE = 3'h2;
  localparam logic [2:0] MODE_INSIDE = 3'h3;
  localparam logic [2:0] MODE_OUTSIDE = 3'h4;
  typedef struct packed {
    logic window_match_flag;
    logic sample_done_flag;
  } arw_flags_t;
  typedef enum logic {ST_IDLE, ST_BUSY} arw_state_t;
endpackage

/* File: rtl/arw_top.sv */
// result, window compare, flags and 16-bit staging behind a classic Wishbone slave
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module arw_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic debug_halt_i,
  input wire logic start_event_i,
  input wire logic sample_valid_i,
  input wire logic signed [11:0] sample_i,
  output logic conv_start_o,
  output logic irq_o
);
  import arw_pkg::*;

  // ******************************
  // bus decode
  // ******************************
  logic req;
  logic wr;
  logic rd;
  logic [5:0] idx;
  logic [7:0] wbyte;
  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i && sel_i[0];
  assign rd = req && !we_i;
  assign idx = adr_i[7:ADR_LSB];
  assign wbyte = dat_i[7:0];

  // ******************************
  // registers
  // ******************************
  logic [2:0] sample_count;
  logic [2:0] window_mode;
  logic [1:0] irq_enable;
  arw_flags_t flags;
  logic run_when_halted;
  logic [7:0] byte_staging;
  logic [15:0] converted_value;
  logic [15:0] window_low_limit;
  logic [15:0] window_high_limit;
  arw_state_t state;
  logic [15:0] accum;
  logic [6:0] taken;
  logic [6:0] target;
  logic running;
  logic [9:0] code;
  logic [15:0] next_accum;
  logic last;
  logic done;
  logic hit;
  logic res_read;

  // stopped while halted unless told to run through it
  assign running = !debug_halt_i || run_when_halted;
  assign target = COUNT_ONE << sample_count;

  always_comb
  begin
    if (sample_i > $signed({2'b00, CODE_MAX}))
      code = CODE_MAX;
    else if (sample_i < 0)
      code = CODE_MIN;
    else
      code = sample_i[9:0];
  end

  // each term at most 0x3FF, so 64 of them stay at or below the ceiling
  assign next_accum = accum + {6'h00, code};
  assign last = (taken + COUNT_ONE) == target;
  // an abort in the final sample's cycle wins, so no result and no flags
  assign done = (state == ST_BUSY) && running && sample_valid_i && last &&
                !(wr && idx == IDX_START_CONV && !wbyte[BIT_START]);

  function automatic logic window_hit(input logic [2:0] m, input logic [15:0] v,
                                      input logic [15:0] lo, input logic [15:0] hi);
    unique case (m)
      MODE_BELOW: window_hit = v < lo;
      MODE_ABOVE: window_hit = v > hi;
      MODE_INSIDE: window_hit = (v > lo) && (v < hi);
      MODE_OUTSIDE: window_hit = (v < lo) || (v > hi);
      default: window_hit = 1'b0;
    endcase
  endfunction

  // compared on the final sum only, never per sample
  assign hit = window_hit(window_mode, next_accum, window_low_limit, window_high_limit);

  // reading the low result byte is the read that clears the flags
  assign res_read = rd && idx == IDX_CONVERTED_VALUE;

  // ******************************
  // software registers
  // ******************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sample_count <= RST_BYTE[2:0];
      window_mode <= MODE_NONE;
      irq_enable <= RST_BYTE[1:0];
      run_when_halted <= 1'b0;
      window_low_limit <= RST_WORD;
      window_high_limit <= RST_WORD;
    end
    else if (wr)
    begin
      unique case (idx)
        IDX_SAMPLE_COUNT:
          sample_count <= (wbyte[2:0] > COUNT_MAX_LOG2) ? COUNT_MAX_LOG2 : wbyte[2:0];
        IDX_WINDOW_MODE: window_mode <= wbyte[2:0];
        IDX_IRQ_ENABLE: irq_enable <= wbyte[1:0];
        IDX_HALT_BEHAVIOUR: run_when_halted <= wbyte[BIT_RUN_WHEN_HALTED];
        // high byte write commits the staged low byte in one go
        IDX_WINDOW_LOW_LIMIT + IDX_HIGH_BYTE:
          window_low_limit <= {wbyte, byte_staging};
        IDX_WINDOW_HIGH_LIMIT + IDX_HIGH_BYTE:
          window_high_limit <= {wbyte, byte_staging};
        default: ;
      endcase
    end
  end

  // ******************************
  // shared staging byte
  // ******************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      byte_staging <= RST_BYTE;
    else if (wr && (idx == IDX_BYTE_STAGING || idx == IDX_WINDOW_LOW_LIMIT ||
                    idx == IDX_WINDOW_HIGH_LIMIT))
      byte_staging <= wbyte;
    else if (rd && idx == IDX_CONVERTED_VALUE)
      byte_staging <= converted_value[15:8];
    else if (rd && idx == IDX_WINDOW_LOW_LIMIT)
      byte_staging <= window_low_limit[15:8];
    else if (rd && idx == IDX_WINDOW_HIGH_LIMIT)
      byte_staging <= window_high_limit[15:8];
  end

  // ******************************
  // conversion sequencer
  // ******************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      accum <= RST_WORD;
      taken <= COUNT_ZERO;
      conv_start_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          // events count only while running
          if ((wr && idx == IDX_START_CONV && wbyte[BIT_START]) ||
              (start_event_i && running))
          begin
            state <= ST_BUSY;
            accum <= RST_WORD;
            taken <= COUNT_ZERO;
            conv_start_o <= running;
          end
        end
        ST_BUSY:
        begin
          if (wr && idx == IDX_START_CONV && !wbyte[BIT_START])
            state <= ST_IDLE;
          else if (running && sample_valid_i)
          begin
            accum <= next_accum;
            taken <= taken + COUNT_ONE;
            if (last)
              state <= ST_IDLE;
            else
              conv_start_o <= 1'b1;
          end
        end
      endcase
    end
  end

  // ******************************
  // result register
  // ******************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      converted_value <= RST_WORD;
    else if (done)
      converted_value <= next_accum;
  end

  // ******************************
  // flags and interrupt
  // ******************************
  arw_flags_t next_flags;
  always_comb
  begin
    next_flags = flags;
    if (wr && idx == IDX_IRQ_FLAGS)
    begin
      if (wbyte[BIT_WINDOW_MATCH])
        next_flags.window_match_flag = 1'b0;
      if (wbyte[BIT_SAMPLE_DONE])
        next_flags.sample_done_flag = 1'b0;
    end
    if (res_read)
      next_flags = '0;
    // a completion in the clearing cycle wins
    if (done)
    begin
      next_flags.sample_done_flag = 1'b1;
      if (hit)
        next_flags.window_match_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      irq_o <= |(next_flags & irq_enable);
    end
  end

  // ******************************
  // read mux and acknowledge
  // ******************************
  logic [7:0] rbyte;
  always_comb
  begin
    rbyte = RST_BYTE;
    unique case (idx)
      IDX_SAMPLE_COUNT: rbyte = {5'h00, sample_count};
      IDX_WINDOW_MODE: rbyte = {5'h00, window_mode};
      IDX_START_CONV: rbyte = {7'h00, state == ST_BUSY};
      IDX_IRQ_ENABLE: rbyte = {6'h00, irq_enable};
      IDX_IRQ_FLAGS: rbyte = {6'h00, flags};
      IDX_HALT_BEHAVIOUR: rbyte = {7'h00, run_when_halted};
      IDX_BYTE_STAGING: rbyte = byte_staging;
      IDX_CONVERTED_VALUE: rbyte = converted_value[7:0];
      IDX_WINDOW_LOW_LIMIT: rbyte = window_low_limit[7:0];
      IDX_WINDOW_HIGH_LIMIT: rbyte = window_high_limit[7:0];
      // high halves come from the byte latched by the low read
      IDX_CONVERTED_VALUE + IDX_HIGH_BYTE: rbyte = byte_staging;
      IDX_WINDOW_LOW_LIMIT + IDX_HIGH_BYTE: rbyte = byte_staging;
      IDX_WINDOW_HIGH_LIMIT + IDX_HIGH_BYTE: rbyte = byte_staging;
      default: rbyte = RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= req;
      dat_o <= {24'h000000, rd ? rbyte : RST_BYTE};
    end
  end

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_match_on_hit: assert property (done && hit |=> flags.window_match_flag)
    else $error("window match not set on hit");
  chk_match_needs_done: assert property
    (!$past(flags.window_match_flag) && flags.window_match_flag |-> $past(done && hit))
    else $error("window match set without hit");
  chk_res_read_clear: assert property
    (res_read && !done |=> flags == '0)
    else $error("result read did not clear flags");
  chk_w1c_clear: assert property
    (wr && idx == IDX_IRQ_FLAGS && wbyte[BIT_SAMPLE_DONE] && !done
     |=> !flags.sample_done_flag)
    else $error("write one did not clear done flag");
  chk_done_sets: assert property
    (done |=> flags.sample_done_flag && converted_value == $past(next_accum))
    else $error("completion not recorded");
  chk_halt_freeze: assert property
    (debug_halt_i && !run_when_halted && state == ST_BUSY && !wr
     |=> $stable(accum) && state == ST_BUSY)
    else $error("block moved while halted");
  chk_sat_range: assert property (converted_value <= ACC_CEILING)
    else $error("result above ceiling");
  chk_irq_level: assert property
    (##1 irq_o == |($past(next_flags) & $past(irq_enable)))
    else $error("interrupt level wrong");
  chk_busy_bit: assert property
    (state == ST_BUSY && done |=> state == ST_IDLE)
    else $error("start bit did not self clear");
  chk_ack_one: assert property (req |=> ack_o ##1 !ack_o)
    else $error("ack not single cycle");

  cov_match: cover property (done && hit);
  cov_clear_race: cover property (done && res_read);
  cov_halt_run: cover property (debug_halt_i && run_when_halted && done);
  cov_irq: cover property (!irq_o ##1 irq_o);
endmodule

/* File: tb/arw_top_tb.sv */
// self-checking bench of the result/window block against a behavioural model
`timescale 1ns/1ps
module arw_top_tb;
  import arw_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic debug_halt_i = 1'b0;
  logic start_event_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic signed [11:0] sample_i = 12'sh000;
  logic [31:0] dat_o;
  logic ack_o, conv_start_o, irq_o;
  logic [7:0] q;
  logic [15:0] v;
  logic [3:0] lane = 4'hF;
  logic [5:0] rst_idx [10] = '{6'h3F, 6'h0B, 6'h0C, 6'h0D, 6'h10,
    6'h11, 6'h12, 6'h13, 6'h14, 6'h15};
  int err_count = 0;
  int total_checks = 0;
  int starts = 0;
  int cycles = 0;
  int last = 0;
  int k;

  arw_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .debug_halt_i(debug_halt_i), .start_event_i(start_event_i),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i), .conv_start_o(conv_start_o),
    .irq_o(irq_o));

  always #2.5 clk_i = ~clk_i;

  // ****************************
  // sample requests and run limit
  // ****************************
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (conv_start_o === 1'b1)
      starts <= starts + 1;
  end

  always @(posedge clk_i)
    if (cycles == 20000)
    begin
      err_count++;
      close_out();
    end

  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ****************************
  // classic bus cycles
  // ****************************
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    sel_i <= lane;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1);
    // registered ack: request taken one edge after launch, ack seen at the next
    check("bus latency", 16'h0002, 16'(n));
    q = dat_o[7:0];
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask

  task automatic wr16(input logic [5:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d[7:0]);
    bus(1'b1, idx + IDX_HIGH_BYTE, d[15:8]);
  endtask

  task automatic rd16(input logic [5:0] idx, output logic [15:0] d);
    bus(1'b0, idx, 8'h00);
    d[7:0] = q;
    bus(1'b0, idx + IDX_HIGH_BYTE, 8'h00);
    d[15:8] = q;
  endtask

  task automatic pulse_event();
    @(posedge clk_i);
    start_event_i <= 1'b1;
    @(posedge clk_i);
    start_event_i <= 1'b0;
  endtask

  // ****************************
  // one measurement against the model
  // ****************************
  task automatic conv(input int mode, input logic [2:0] cl, input logic ev, input logic maxed);
    int n, sum, lo, hi, s, b;
    int samples[$];
    logic m;
    logic [1:0] en, fl, wc;
    logic [15:0] r;
    n = 1 << ((cl > 6) ? 6 : cl);
    lo = $urandom_range(1023 * n, 0);
    hi = $urandom_range(1023 * n, lo);
    en = 2'($urandom);
    wr16(IDX_WINDOW_LOW_LIMIT, 16'(lo));
    wr16(IDX_WINDOW_HIGH_LIMIT, 16'(hi));
    rd16(IDX_WINDOW_HIGH_LIMIT, r);
    check("high limit", 16'(hi), r);
    bus(1'b1, IDX_SAMPLE_COUNT, {5'h00, cl});
    bus(1'b1, IDX_WINDOW_MODE, 8'(mode));
    bus(1'b1, IDX_IRQ_ENABLE, {6'h00, en});
    b = starts;
    if (ev)
      pulse_event();
    else
      bus(1'b1, IDX_START_CONV, 8'h01);
    bus(1'b0, IDX_START_CONV, 8'h00);
    check("start bit busy", 16'h0001, {8'h00, q});
    sum = 0;
    for (int i = 0; i < n; i++)
    begin
      for (int t = 0; t < 50 && starts <= b + i; t++)
        @(posedge clk_i);
      check("sample request", 16'(b + i + 1), 16'(starts));
      s = maxed ? 2047 : $urandom_range(4095, 0) - 2048;
      sample_i <= 12'(s);
      sample_valid_i <= 1'b1;
      @(posedge clk_i);
      sample_valid_i <= 1'b0;
      samples.push_back((s < 0) ? 0 : (s > 1023) ? 1023 : s);
    end
    sum = samples.sum();
    repeat (2) @(posedge clk_i);
    case (mode)
      1: m = sum < lo;
      2: m = sum > hi;
      3: m = lo < sum && sum < hi;
      4: m = sum < lo || sum > hi;
      default: m = 1'b0;
    endcase
    fl = {m, 1'b1};
    last = sum;
    check("irq level", 16'((fl & en) != 2'b00), 16'(irq_o));
    bus(1'b0, IDX_START_CONV, 8'h00);
    check("start bit idle", 16'h0000, {8'h00, q});
    bus(1'b0, IDX_IRQ_FLAGS, 8'h00);
    check("flags set", {14'h0000, fl}, {8'h00, q});
    bus(1'b1, IDX_IRQ_FLAGS, 8'h00);
    bus(1'b0, IDX_IRQ_FLAGS, 8'h00);
    check("flags kept", {14'h0000, fl}, {8'h00, q});
    wc = mode[0] ? 2'b10 : 2'b01;
    bus(1'b1, IDX_IRQ_FLAGS, {6'h00, wc});
    bus(1'b0, IDX_IRQ_FLAGS, 8'h00);
    check("flags one cleared", {14'h0000, fl & ~wc}, {8'h00, q});
    rd16(IDX_CONVERTED_VALUE, r);
    check("converted value", 16'(sum), r);
    bus(1'b0, IDX_IRQ_FLAGS, 8'h00);
    check("flags read cleared", 16'h0000, {8'h00, q});
    check("irq cleared", 16'h0000, 16'(irq_o));
  endtask

  initial
  begin
    void'($urandom(32'h2C4091D5));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, 6'h3F, 8'hFF);
    foreach (rst_idx[i])
    begin
      bus(1'b0, rst_idx[i], 8'h00);
      check("reset value", 16'h0000, {8'h00, q});
    end
    bus(1'b1, IDX_BYTE_STAGING, 8'hA5);
    bus(1'b0, IDX_BYTE_STAGING, 8'h00);
    check("staging", 16'h00A5, {8'h00, q});
    bus(1'b1, IDX_WINDOW_LOW_LIMIT + IDX_HIGH_BYTE, 8'h3C);
    rd16(IDX_WINDOW_LOW_LIMIT, v);
    check("low limit pair", 16'h3CA5, v);
    lane = 4'hE;
    bus(1'b1, IDX_BYTE_STAGING, 8'h11);
    lane = 4'hF;
    bus(1'b0, IDX_BYTE_STAGING, 8'h00);
    check("lane ignored", 16'h003C, {8'h00, q});
    for (int md = 0; md < 6; md++)
      conv(md, 3'($urandom_range(3, 0)), 1'b0, 1'b0);
    conv(4, 3'h7, 1'b0, 1'b1);
    wr16(IDX_CONVERTED_VALUE, 16'h5A5A);
    rd16(IDX_CONVERTED_VALUE, v);
    check("read only result", 16'(last), v);
    bus(1'b1, IDX_HALT_BEHAVIOUR, 8'h00);
    debug_halt_i <= 1'b1;
    k = starts;
    pulse_event();
    repeat (8) @(posedge clk_i);
    check("halted request", 16'(k), 16'(starts));
    bus(1'b0, IDX_START_CONV, 8'h00);
    check("halted idle", 16'h0000, {8'h00, q});
    // software start while frozen: busy, but no request and samples ignored
    bus(1'b1, IDX_SAMPLE_COUNT, 8'h00);
    bus(1'b1, IDX_START_CONV, 8'h01);
    sample_valid_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sample_valid_i <= 1'b0;
    bus(1'b0, IDX_START_CONV, 8'h00);
    check("halted busy", 16'h0001, {8'h00, q});
    check("halted no request", 16'(k), 16'(starts));
    bus(1'b0, IDX_IRQ_FLAGS, 8'h00);
    check("halted flags", 16'h0000, {8'h00, q});
    rd16(IDX_CONVERTED_VALUE, v);
    check("halted result", 16'(last), v);
    bus(1'b1, IDX_START_CONV, 8'h00);
    bus(1'b0, IDX_START_CONV, 8'h00);
    check("abort idle", 16'h0000, {8'h00, q});
    bus(1'b1, IDX_HALT_BEHAVIOUR, 8'h01);
    bus(1'b0, IDX_HALT_BEHAVIOUR, 8'h00);
    check("halt behaviour", 16'h0001, {8'h00, q});
    conv(3, 3'h1, 1'b1, 1'b0);
    close_out();
  end
endmodule
